//--- bench/slc_config_regs_assertions.sv
// Port checks for the loop configuration register bank.
// Assumes binding into slc_config_regs, one clock, rstn active low.
`timescale 1ns/10ps
module slc_assertions #(
  parameter int ADDR_W = 8
) (
  input wire logic                    clk,
  input wire logic                    rstn,
  input wire logic [ADDR_W-1:0]       s_axi_awaddr,
  input wire logic                    s_axi_awvalid,
  input wire logic                    s_axi_awready,
  input wire logic [31:0]             s_axi_wdata,
  input wire logic [3:0]              s_axi_wstrb,
  input wire logic                    s_axi_wvalid,
  input wire logic                    s_axi_wready,
  input wire logic                    s_axi_bvalid,
  input wire logic                    s_axi_bready,
  input wire logic                    s_axi_arvalid,
  input wire logic                    s_axi_arready,
  input wire logic [31:0]             s_axi_rdata,
  input wire logic                    s_axi_rvalid,
  input wire logic                    s_axi_rready,
  input wire slc_pkg::slc_loop_ctrl_s loopCtrl
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  sequence wr_go;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      && !s_axi_bvalid;
  endsequence
  // A word lands on the loop outputs on the edge after both halves pass, together with bvalid.
  sequence wr_at(a, b);
    wr_go ##0 (s_axi_awaddr == a && s_axi_wstrb[b]);
  endsequence
  a_reset_values: assert property (
    $rose(rstn) |-> loopCtrl == {2'h0, 3'h2, 6'h10, 5'h10, 6'h20})
    else $error("loop outputs wrong after reset");
  a_total_sum: assert property (
    loopCtrl.extPumpTotalCurrent == 6'(loopCtrl.extPumpDownCurrent)
      + 6'(loopCtrl.extPumpUpCurrent)) else $error("total current wrong");
  a_dither_write: assert property (wr_at(8'hbc, 1) |-> ##3
    loopCtrl.ditherLevel == $past(s_axi_wdata[14:13], 3))
    else $error("dither level not taken from write");
  a_core_write: assert property (wr_at(8'hb8, 0) |-> ##3
    {loopCtrl.corePresetEnable, loopCtrl.startCoreChoice}
      == $past(s_axi_wdata[2:0], 3)) else $error("core preset wrong");
  a_pump_write: assert property (wr_at(8'ha8, 0) |-> ##3
    {loopCtrl.extPumpPolarity, loopCtrl.extPumpDownCurrent}
      == $past(s_axi_wdata[5:0], 3)) else $error("pump word wrong");
  a_write_resp: assert property (
    wr_go |-> ##2 s_axi_bvalid) else $error("write response late");
  a_read_resp: assert property (s_axi_arvalid && s_axi_arready
    |=> s_axi_rvalid && s_axi_rdata[31:16] == 16'h0)
    else $error("read answer late or upper half set");
  a_write_hold: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid) else $error("write response dropped");
  a_read_hold: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data not held");
endmodule // slc_assertions

bind slc_config_regs slc_assertions #(.ADDR_W(ADDR_W)) chk (.*);

//--- bench/tb.sv
// Self-checking bench for the loop configuration register bank.
// Assumes slc_config_regs and its checker are compiled before it.
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin checked++; if ((got) !== (ex)) begin \
  num_errors++; $display("wrong value %s exp %h got %h", nm, ex, got); end end
module tb;
  logic                    clk, rstn, s_axi_awvalid, s_axi_awready;
  logic                    s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic                    s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic                    s_axi_rvalid, s_axi_rready;
  logic [7:0]              s_axi_awaddr, s_axi_araddr;
  logic [31:0]             s_axi_wdata, s_axi_rdata;
  logic [3:0]              s_axi_wstrb;
  logic [1:0]              s_axi_bresp, s_axi_rresp;
  slc_pkg::slc_loop_ctrl_s loopCtrl;
  logic [15:0]             mdl [4];
  logic [7:0]              adr [5] = '{8'ha4, 8'ha8, 8'hb8, 8'hbc, 8'hc0};
  int                      num_errors = 0, checked = 0, seed = 95;

  slc_config_regs #(.ADDR_W(8)) uut (.*);

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Host words keep the fixed patterns; up and down codes match and are even.
  function automatic logic [15:0] legal(int i, logic [31:0] r, int k);
    logic [4:0] c;
    c = 5'(2 * (k % 16));
    case (i)
      0: return {4'h0, c, r[6:0]};
      1: return {10'h8, r[0], c};
      2: return {13'h3, r[2], 2'(k % 3)};
      3: return {1'b0, 2'(k), 13'h0};
      default: return r[15:0];
    endcase
  endfunction

  function automatic slc_pkg::slc_loop_ctrl_s exp_ctrl();
    return {mdl[3][14:13], mdl[2][2:0], mdl[1][5:0], mdl[0][11:7],
            6'(mdl[1][4:0]) + 6'(mdl[0][11:7])};
  endfunction

  task automatic wr(input int i, input logic [31:0] d, input logic [3:0] s);
    logic ga, gw, gb;
    logic [1:0] r;
    int n;
    n = 0;
    gb = 1'b0;
    s_axi_awaddr <= adr[i];
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_wvalid <= 1'b1;
    while (!gb && n++ < 20) begin
      @(negedge clk);
      ga = s_axi_awready;
      gw = s_axi_wready;
      gb = s_axi_bvalid && s_axi_bready;
      r = s_axi_bresp;
      @(posedge clk);
      if (ga) s_axi_awvalid <= 1'b0;
      if (gw) s_axi_wvalid <= 1'b0;
      s_axi_bready <= !gb && (s_axi_bready || 1'($random(seed)));
    end
    `CHK("bresp", (i < 4) ? 2'h0 : 2'h2, r)
    if (i < 4 && s[0]) mdl[i][7:0] = d[7:0];
    if (i < 4 && s[1]) mdl[i][15:8] = d[15:8];
    @(negedge clk);
    `CHK("loopCtrl", exp_ctrl(), loopCtrl)
    @(posedge clk);
  endtask

  task automatic rd(input int i);
    logic ga, gr;
    logic [31:0] d;
    logic [1:0] r;
    int n;
    n = 0;
    gr = 1'b0;
    s_axi_araddr <= adr[i];
    s_axi_arvalid <= 1'b1;
    while (!gr && n++ < 20) begin
      @(negedge clk);
      ga = s_axi_arready;
      gr = s_axi_rvalid && s_axi_rready;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge clk);
      if (ga) s_axi_arvalid <= 1'b0;
      s_axi_rready <= !gr && (s_axi_rready || 1'($random(seed)));
    end
    `CHK("rdata", (i < 4) ? {16'h0, mdl[i]} : 32'h0, d)
    `CHK("rresp", (i < 4) ? 2'h0 : 2'h2, r)
  endtask

  task automatic do_reset();
    rstn <= 1'b0;
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    mdl = '{16'h0810, 16'h0210, 16'h001a, 16'h0000};
    @(negedge clk);
    `CHK("loopCtrl", exp_ctrl(), loopCtrl)
    @(posedge clk);
    for (int i = 0; i < 5; i++) rd(i);
  endtask

  task automatic wrap_up();
    if (num_errors == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    wrap_up();
  end

  initial begin
    logic [31:0] r;
    {rstn, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
    s_axi_bready = 1'b0;
    @(posedge clk);
    do_reset();
    for (int k = 0; k < 24; k++) begin
      for (int i = 0; i < 5; i++) begin
        r = $random(seed);
        wr(i, {r[31:16], legal(i, r, k)}, (i == 3) ? r[19:16]
           : {r[19:18], 2'h3});
        rd(int'(r[22:20]) % 5);
      end
    end
    do_reset();
    wrap_up();
  end
endmodule // tb

//--- hw/slc_config_regs.sv
// Register bank holding the synthesizer loop configuration words.
// Assumes one AXI4-Lite master on clk; outputs feed the analog loop.
`timescale 1ns/10ps

module slc_config_regs #(
  parameter int ADDR_W = 8
) (
  input  wire logic                    clk,
  input  wire logic                    rstn,
  input  wire logic [ADDR_W-1:0]       s_axi_awaddr,
  input  wire logic                    s_axi_awvalid,
  output logic                         s_axi_awready,
  input  wire logic [31:0]             s_axi_wdata,
  input  wire logic [3:0]              s_axi_wstrb,
  input  wire logic                    s_axi_wvalid,
  output logic                         s_axi_wready,
  output logic [1:0]                   s_axi_bresp,
  output logic                         s_axi_bvalid,
  input  wire logic                    s_axi_bready,
  input  wire logic [ADDR_W-1:0]       s_axi_araddr,
  input  wire logic                    s_axi_arvalid,
  output logic                         s_axi_arready,
  output logic [31:0]                  s_axi_rdata,
  output logic [1:0]                   s_axi_rresp,
  output logic                         s_axi_rvalid,
  input  wire logic                    s_axi_rready,
  output slc_pkg::slc_loop_ctrl_s      loopCtrl
);

  // ****************************************************************
  // State.
  // ****************************************************************
  typedef struct packed {
    logic [15:0]             upWord;
    logic [15:0]             pumpWord;
    logic [15:0]             coreWord;
    logic [15:0]             ditherWord;
    logic                    awHeld;
    logic [ADDR_W-1:0]       awAddr;
    logic                    wHeld;
    logic [15:0]             wData;
    logic [1:0]              wStrb;
    logic                    awRdy;
    logic                    wRdy;
    logic                    bValid;
    logic [1:0]              bResp;
    logic                    arRdy;
    logic                    rValid;
    logic [31:0]             rData;
    logic [1:0]              rResp;
    slc_pkg::slc_loop_ctrl_s ctrl;
  } slc_state_s;

  slc_state_s st_r;
  slc_state_s st_nxt;

  // Word index of a byte address; the low two bits select a lane only.
  function automatic logic [5:0] wordIndex(input logic [ADDR_W-1:0] a);
    wordIndex = 6'(a >> 2);
  endfunction

  // True when a word index names one of the four stored words. Both the
  // write and the read path decode with it, so they never disagree on
  // which addresses answer with an error.
  function automatic logic isMapped(input logic [5:0] i);
    isMapped = (i == slc_pkg::IDX_EXT_PUMP_UP_WORD)   ||
               (i == slc_pkg::IDX_EXT_PUMP_POLARITY)  ||
               (i == slc_pkg::IDX_OSC_CORE_PRESELECT) ||
               (i == slc_pkg::IDX_MODULATOR_DITHER);
  endfunction

  // Byte-lane merge of the low half-word.
  function automatic logic [15:0] mergeLanes(input logic [15:0] old,
                                             input logic [15:0] dat,
                                             input logic [1:0]  strb);
    mergeLanes = {strb[1] ? dat[15:8] : old[15:8],
                  strb[0] ? dat[7:0]  : old[7:0]};
  endfunction

  // ****************************************************************
  // Next state.
  // ****************************************************************
  always_comb begin
    logic [5:0]  idx;
    logic        hit;
    logic [15:0] rd;
    idx    = 6'h00;
    hit    = 1'b0;
    rd     = 16'h0000;
    st_nxt = st_r;

    // Address and data may arrive in either order; each is parked.
    if (s_axi_awvalid && st_r.awRdy) begin
      st_nxt.awHeld = 1'b1;
      st_nxt.awAddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && st_r.wRdy) begin
      st_nxt.wHeld = 1'b1;
      st_nxt.wData = s_axi_wdata[15:0];
      st_nxt.wStrb = s_axi_wstrb[1:0];
    end
    if (st_r.bValid && s_axi_bready) begin
      st_nxt.bValid = 1'b0;
    end

    // Commit once both halves are parked and the last answer is gone.
    // All sixteen bits are stored so that every bit reads back.
    if (st_r.awHeld && st_r.wHeld && !st_r.bValid) begin
      idx = wordIndex(st_r.awAddr);
      hit = isMapped(idx);
      case (idx)
        slc_pkg::IDX_EXT_PUMP_UP_WORD:
          st_nxt.upWord = mergeLanes(st_r.upWord, st_r.wData,
                                     st_r.wStrb);
        slc_pkg::IDX_EXT_PUMP_POLARITY:
          st_nxt.pumpWord = mergeLanes(st_r.pumpWord, st_r.wData,
                                       st_r.wStrb);
        slc_pkg::IDX_OSC_CORE_PRESELECT:
          st_nxt.coreWord = mergeLanes(st_r.coreWord, st_r.wData,
                                       st_r.wStrb);
        slc_pkg::IDX_MODULATOR_DITHER:
          st_nxt.ditherWord = mergeLanes(st_r.ditherWord, st_r.wData,
                                         st_r.wStrb);
        default:
          hit = 1'b0;
      endcase
      st_nxt.awHeld = 1'b0;
      st_nxt.wHeld  = 1'b0;
      st_nxt.bValid = 1'b1;
      st_nxt.bResp  = hit ? slc_pkg::RESP_OKAY : slc_pkg::RESP_SLVERR;
    end
    st_nxt.awRdy = !st_nxt.awHeld;
    st_nxt.wRdy  = !st_nxt.wHeld;

    // Read: one cycle from acceptance to rvalid; unmapped reads zero.
    if (st_r.rValid && s_axi_rready) begin
      st_nxt.rValid = 1'b0;
    end
    if (s_axi_arvalid && st_r.arRdy) begin
      idx = wordIndex(s_axi_araddr);
      hit = isMapped(idx);
      case (idx)
        slc_pkg::IDX_EXT_PUMP_UP_WORD:   rd = st_r.upWord;
        slc_pkg::IDX_EXT_PUMP_POLARITY:  rd = st_r.pumpWord;
        slc_pkg::IDX_OSC_CORE_PRESELECT: rd = st_r.coreWord;
        slc_pkg::IDX_MODULATOR_DITHER:   rd = st_r.ditherWord;
        default: begin
          hit = 1'b0;
          rd  = 16'h0000;
        end
      endcase
      st_nxt.rValid = 1'b1;
      st_nxt.rData  = {16'h0000, rd};
      st_nxt.rResp  = hit ? slc_pkg::RESP_OKAY : slc_pkg::RESP_SLVERR;
    end
    st_nxt.arRdy = !st_nxt.rValid;

    // Loop controls follow the committed words on the same edge.
    // Reserved bits are stored but steer nothing; keeping them at
    // their required values is up to software.
    st_nxt.ctrl.ditherLevel = slc_pkg::slc_dither_e'(
      st_nxt.ditherWord[slc_pkg::DITHER_LSB +: 2]);
    st_nxt.ctrl.corePresetEnable =
      st_nxt.coreWord[slc_pkg::PRESET_EN_BIT];
    st_nxt.ctrl.startCoreChoice = slc_pkg::slc_core_e'(
      st_nxt.coreWord[slc_pkg::CORE_CHOICE_LSB +: 2]);
    st_nxt.ctrl.extPumpPolarity =
      st_nxt.pumpWord[slc_pkg::EXT_POL_BIT];
    st_nxt.ctrl.extPumpDownCurrent =
      st_nxt.pumpWord[slc_pkg::EXT_DOWN_LSB +: 5];
    st_nxt.ctrl.extPumpUpCurrent =
      st_nxt.upWord[slc_pkg::EXT_UP_LSB +: 5];
    // Sum in 156.25 uA steps; six bits hold the worst case of 62.
    st_nxt.ctrl.extPumpTotalCurrent =
      {1'b0, st_nxt.pumpWord[slc_pkg::EXT_DOWN_LSB +: 5]} +
      {1'b0, st_nxt.upWord[slc_pkg::EXT_UP_LSB +: 5]};
  end

  // ****************************************************************
  // Registers.
  // ****************************************************************
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_r            <= '0;
      st_r.upWord     <= slc_pkg::RST_EXT_PUMP_UP_WORD;
      st_r.pumpWord   <= slc_pkg::RST_EXT_PUMP_POLARITY;
      st_r.coreWord   <= slc_pkg::RST_OSC_CORE_PRESELECT;
      st_r.ditherWord <= slc_pkg::RST_MODULATOR_DITHER;
      st_r.awRdy      <= 1'b1;
      st_r.wRdy       <= 1'b1;
      st_r.arRdy      <= 1'b1;
      st_r.ctrl       <= slc_pkg::RST_LOOP_CTRL;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign s_axi_awready = st_r.awRdy;
  assign s_axi_wready  = st_r.wRdy;
  assign s_axi_bvalid  = st_r.bValid;
  assign s_axi_bresp   = st_r.bResp;
  assign s_axi_arready = st_r.arRdy;
  assign s_axi_rvalid  = st_r.rValid;
  assign s_axi_rdata   = st_r.rData;
  assign s_axi_rresp   = st_r.rResp;
  assign loopCtrl      = st_r.ctrl;

endmodule // slc_config_regs

//--- hw/slc_pkg.sv
// Constants and types of the synthesizer loop configuration register bank.
// Assumes an AXI4-Lite master with 32-bit data on the same clock.
package slc_pkg;

  // ****************************************************************
  // Register indices; the byte address is four times the index.
  // ****************************************************************
  localparam logic [5:0] IDX_EXT_PUMP_UP_WORD     = 6'h29;
  localparam logic [5:0] IDX_EXT_PUMP_POLARITY    = 6'h2a;
  localparam logic [5:0] IDX_OSC_CORE_PRESELECT   = 6'h2e;
  localparam logic [5:0] IDX_MODULATOR_DITHER     = 6'h2f;

  // ****************************************************************
  // Values after reset.
  // ****************************************************************
  localparam logic [15:0] RST_EXT_PUMP_UP_WORD    = 16'h0810;
  localparam logic [15:0] RST_EXT_PUMP_POLARITY   = 16'h0210;
  localparam logic [15:0] RST_OSC_CORE_PRESELECT  = 16'h001a;
  localparam logic [15:0] RST_MODULATOR_DITHER    = 16'h0000;

  // ****************************************************************
  // Field positions.
  // ****************************************************************
  localparam int DITHER_LSB       = 13;
  localparam int PRESET_EN_BIT    = 2;
  localparam int CORE_CHOICE_LSB  = 0;
  localparam int EXT_POL_BIT      = 5;
  localparam int EXT_DOWN_LSB     = 0;
  localparam int EXT_UP_LSB       = 7;

  // ****************************************************************
  // Bus responses.
  // ****************************************************************
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    DITHER_OFF    = 2'h0,
    DITHER_WEAK   = 2'h1,
    DITHER_MEDIUM = 2'h2,
    DITHER_STRONG = 2'h3
  } slc_dither_e;

  typedef enum logic [1:0] {
    LOW_BAND_CORE  = 2'h0,
    MID_BAND_CORE  = 2'h1,
    HIGH_BAND_CORE = 2'h2,
    CORE_UNUSED    = 2'h3
  } slc_core_e;

  // Control words handed to the analog loop.
  typedef struct packed {
    slc_dither_e ditherLevel;
    logic        corePresetEnable;
    slc_core_e   startCoreChoice;
    logic        extPumpPolarity;
    logic [4:0]  extPumpDownCurrent;
    logic [4:0]  extPumpUpCurrent;
    logic [5:0]  extPumpTotalCurrent;
  } slc_loop_ctrl_s;

  // Loop controls while reset is held; they match the reset words.
  localparam slc_loop_ctrl_s RST_LOOP_CTRL = '{
    ditherLevel:         DITHER_OFF,
    corePresetEnable:    1'b0,
    startCoreChoice:     HIGH_BAND_CORE,
    extPumpPolarity:     1'b0,
    extPumpDownCurrent:  5'h10,
    extPumpUpCurrent:    5'h10,
    extPumpTotalCurrent: 6'h20
  };

endpackage
